// ===== cts_delay.sv
// one-shot cycle delay: done pulses COUNT cycles after start
`timescale 1ns/1ps
`default_nettype none
module cts_delay #(
    parameter int unsigned COUNT = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);
    localparam int unsigned W = $clog2(COUNT + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } cts_dly_type;

    cts_dly_type s;
    cts_dly_type next_s;

    // elaboration-time refusal: a zero count would never raise done
    if (COUNT < 1) begin : g_bad_count
        $error("cts_delay: COUNT must be at least one");
    end

    // restart wins over a running count
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (start_i) begin
            next_s.cnt  = W'(COUNT);
            next_s.busy = 1'b1;
        end else if (s.busy) begin
            if (s.cnt == W'(1)) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.cnt = s.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy_o = s.busy;
    assign done_o = s.done;
endmodule : cts_delay
`default_nettype wire

// ===== cts_mem_model.sv
// behavioural model of the memory access logic behind the tag state machine
`timescale 1ns/1ps
`default_nettype none
module cts_mem_model #(
    parameter int unsigned LATENCY = 3
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic mem_req_i,
    input  wire logic fail_mode_i,
    output logic      mem_done_o,
    output logic      mem_fail_o
);
    int unsigned count;
    logic        busy;

    // answers each issued command after a fixed latency; fail only on demand
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy       <= 1'b0;
            count      <= 0;
            mem_done_o <= 1'b0;
            mem_fail_o <= 1'b0;
        end else begin
            mem_done_o <= 1'b0;
            mem_fail_o <= ~mem_fail_o; // meaningless outside done, so never steady
            if (mem_req_i) begin
                busy  <= 1'b1;
                count <= LATENCY;
            end else if (busy) begin
                if (count == 0) begin
                    busy       <= 1'b0;
                    mem_done_o <= 1'b1;
                    mem_fail_o <= fail_mode_i;
                end else begin
                    count <= count - 1;
                end
            end
        end
    end
endmodule : cts_mem_model
`default_nettype wire

// ===== cts_pkg.sv
// constants and types of the contactless tag protocol state machine
package cts_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned STARTUP_TIME_NS  = 120000;
    localparam int unsigned STARTUP_CYCLES   =
        (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REPLY_DELAY_NS   = 100000;
    localparam int unsigned REPLY_DELAY_CYCLES = REPLY_DELAY_NS / CLK_PERIOD_NS;

    // opcodes
    localparam logic [7:0] OP_REQA              = 8'h26;
    localparam logic [7:0] OP_WUPA              = 8'h52;
    localparam logic [7:0] OP_CASCADE1          = 8'h93;
    localparam logic [7:0] OP_CASCADE2          = 8'h95;
    localparam logic [7:0] NVB_SELECT           = 8'h70;
    localparam logic [7:0] OP_HALT              = 8'h50;
    localparam logic [7:0] OP_READ_FOUR_BLOCKS  = 8'h30;
    localparam logic [7:0] OP_READ_TWO_BLOCKS   = 8'h31;
    localparam logic [7:0] OP_WRITE_ONE_BLOCK   = 8'hA2;
    localparam logic [7:0] OP_WRITE_COMPAT      = 8'hA0;
    localparam logic [7:0] OP_WRITE_TWO_BLOCKS  = 8'hA1;

    // frame lengths in bytes, crc included
    localparam logic [4:0] LEN_READ             = 5'h04;
    localparam logic [4:0] LEN_HALT             = 5'h04;
    localparam logic [4:0] LEN_SELECT           = 5'h09;
    localparam logic [4:0] LEN_WRITE_ONE        = 5'h08;
    localparam logic [4:0] LEN_WRITE_TWO        = 5'h0C;
    localparam logic [4:0] LEN_WRITE_COMPAT     = 5'h14;

    // address limit and 4-bit answers
    localparam logic [7:0] ADDR_TOP             = 8'h0F;
    localparam logic [3:0] NIB_ACK              = 4'hA;
    localparam logic [3:0] NIB_NACK_ADDRESS     = 4'h0;
    localparam logic [3:0] NIB_NACK_INTEGRITY   = 4'h1;

    // configuration byte: position of the password protection flag
    localparam int unsigned CFG_PROTECT_BIT     = 0;
    localparam logic [7:0]  CFG_RESET           = 8'h00;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_READY1 = 5'h02,
        ST_READY2 = 5'h04,
        ST_ACTIVE = 5'h08,
        ST_HALT   = 5'h10
    } cts_state_type;

    typedef enum logic [2:0] {
        RPL_ATQA     = 3'h0,
        RPL_UID_CL1  = 3'h1,
        RPL_UID_CL2  = 3'h2,
        RPL_SAK_PART = 3'h3,
        RPL_SAK_DONE = 3'h4,
        RPL_MEM_DATA = 3'h5,
        RPL_NIBBLE   = 3'h6
    } cts_reply_type;

endpackage : cts_pkg

// ===== cts_tag_fsm.sv
// protocol state machine of a contactless proximity tag
`timescale 1ns/1ps
`default_nettype none
// Contract
// - power-on enters idle; request or wake-up moves to ready1; other frames ignored
// - in idle every other command is silent and idle is kept
// - halt left only by wake-up into starred ready1; all else silent
// - good halt command in active: no reply, go to halt
// - ready1 answers cascade-1 anticollision/select; select gives partial sak, ready2
// - ready2 answers cascade-2 anticollision/select; select gives final sak, active
// - valid two/four block read in ready executes and jumps to active
// - other commands in ready are silent errors returning to idle or halt
// - origin from idle or halt is remembered so errors return there
// - memory access only in active; reader selects first except read shortcut
// - protection flag without verification limits upper memory; verification frees it
// - commands are taken only after the start-up delay
// - configuration byte latched on each executed request or wake-up only
// - replies start after a fixed deterministic delay
// - outside active only valid frames answered; errors other than reads in ready silent and fall back
// - active: bad opcode or length silent, integrity error integrity nack
// - active: bad address or other error gets address nack, then fall back
// - reads in ready get the active error answers
// - ack and nacks are 4-bit codes A, 0 and 1
// - read addresses 00 to 0F accepted, others nacked
// - halt accepts parameter 00 to 0F with correct crc
module cts_tag_fsm
    import cts_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          frame_valid_i,
    input  wire logic          frame_short_i,
    input  wire logic [7:0]    frame_cmd_i,
    input  wire logic [7:0]    frame_arg_i,
    input  wire logic [4:0]    frame_len_i,
    input  wire logic          frame_integrity_err_i,
    input  wire logic          uid_match_i,
    input  wire logic [7:0]    cfg_byte_i,
    input  wire logic          pwd_ok_i,
    input  wire logic          mem_done_i,
    input  wire logic          mem_fail_i,
    output cts_state_type      state_o,
    output logic               from_halt_o,
    output logic               ready_o,
    output logic [7:0]         cfg_o,
    output logic               access_limited_o,
    output logic               mem_req_o,
    output logic [7:0]         mem_op_o,
    output logic [7:0]         mem_addr_o,
    output logic               reply_valid_o,
    output cts_reply_type      reply_kind_o,
    output logic [3:0]         reply_nibble_o
);
    typedef struct packed {
        cts_state_type state;
        logic          from_halt;
        logic          boot_go;
        logic          ready;
        logic [7:0]    cfg;
        logic          verified;
        logic          limited;
        logic          mem_wait;
        logic          mem_req;
        logic [7:0]    mem_op;
        logic [7:0]    mem_addr;
        logic          rpl_start;
        logic          rpl_pend;
        logic          rpl_valid;
        cts_reply_type rpl_kind;
        logic [3:0]    rpl_nib;
    } cts_fsm_type;

    cts_fsm_type s;
    cts_fsm_type next_s;
    logic        boot_done;
    logic        rpl_done;

    // start-up delay, launched by the first edge after reset
    cts_delay #(.COUNT(STARTUP_CYCLES)) u_boot (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (s.boot_go),
        .busy_o  (),
        .done_o  (boot_done)
    );

    // fixed reply delay keeps several tags bit-synchronous
    cts_delay #(.COUNT(REPLY_DELAY_CYCLES)) u_reply (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (s.rpl_start),
        .busy_o  (),
        .done_o  (rpl_done)
    );

    // frame classification
    logic fv, reqa, wupa, is_read, is_write, is_halt, addr_ok, len_ok, in_ready;
    assign fv       = frame_valid_i && s.ready && !s.rpl_pend && !s.mem_wait;
    assign reqa     = frame_short_i && frame_cmd_i == OP_REQA;
    assign wupa     = frame_short_i && frame_cmd_i == OP_WUPA;
    assign is_read  = !frame_short_i && (frame_cmd_i == OP_READ_TWO_BLOCKS ||
                                         frame_cmd_i == OP_READ_FOUR_BLOCKS);
    assign is_write = !frame_short_i && (frame_cmd_i == OP_WRITE_ONE_BLOCK ||
                                         frame_cmd_i == OP_WRITE_TWO_BLOCKS ||
                                         frame_cmd_i == OP_WRITE_COMPAT);
    assign is_halt  = !frame_short_i && frame_cmd_i == OP_HALT;
    assign addr_ok  = frame_arg_i <= ADDR_TOP;
    assign in_ready = s.state == ST_READY1 || s.state == ST_READY2;

    // expected length per opcode; writes checked further by memory logic
    always_comb begin
        len_ok = 1'b0;
        if (is_read) begin
            len_ok = frame_len_i == LEN_READ;
        end else if (is_halt) begin
            len_ok = frame_len_i == LEN_HALT;
        end else if (frame_cmd_i == OP_WRITE_ONE_BLOCK) begin
            len_ok = frame_len_i == LEN_WRITE_ONE;
        end else if (frame_cmd_i == OP_WRITE_TWO_BLOCKS) begin
            len_ok = frame_len_i == LEN_WRITE_TWO;
        end else if (frame_cmd_i == OP_WRITE_COMPAT) begin
            len_ok = frame_len_i == LEN_WRITE_COMPAT;
        end
    end

    // next-state logic; frames arriving while busy are dropped
    always_comb begin
        logic          do_rpl;
        logic          fall;
        logic          issue;
        cts_reply_type rk;
        logic [3:0]    rn;
        logic [7:0]    casc;
        do_rpl = 1'b0;
        fall   = 1'b0;
        issue  = 1'b0;
        rk     = RPL_NIBBLE;
        rn     = NIB_ACK;
        casc   = (s.state == ST_READY2) ? OP_CASCADE2 : OP_CASCADE1;
        next_s = s;
        next_s.boot_go   = 1'b0;
        next_s.mem_req   = 1'b0;
        next_s.rpl_start = 1'b0;
        next_s.rpl_valid = 1'b0;
        if (boot_done) begin
            next_s.ready = 1'b1;
        end
        if (rpl_done) begin
            next_s.rpl_pend  = 1'b0;
            next_s.rpl_valid = 1'b1;
        end
        if (pwd_ok_i && s.state == ST_ACTIVE) begin
            next_s.verified = 1'b1;
        end
        if (fv) begin
            unique case (s.state)
                ST_IDLE: begin
                    // anything but request or wake-up leaves idle untouched
                    if (!frame_integrity_err_i && (reqa || wupa)) begin
                        next_s.state     = ST_READY1;
                        next_s.from_halt = 1'b0;
                        next_s.cfg       = cfg_byte_i;
                        next_s.verified  = 1'b0;
                        do_rpl = 1'b1;
                        rk     = RPL_ATQA;
                    end
                end
                ST_HALT: begin
                    if (!frame_integrity_err_i && wupa) begin
                        next_s.state     = ST_READY1;
                        next_s.from_halt = 1'b1;
                        next_s.cfg       = cfg_byte_i;
                        next_s.verified  = 1'b0;
                        do_rpl = 1'b1;
                        rk     = RPL_ATQA;
                    end
                end
                ST_READY1, ST_READY2: begin
                    if (is_read) begin
                        if (frame_integrity_err_i) begin
                            fall = 1'b1; do_rpl = 1'b1; rn = NIB_NACK_INTEGRITY;
                        end else if (!len_ok) begin
                            fall = 1'b1;
                        end else if (!addr_ok) begin
                            fall = 1'b1; do_rpl = 1'b1; rn = NIB_NACK_ADDRESS;
                        end else begin
                            next_s.state = ST_ACTIVE;
                            issue = 1'b1;
                        end
                    end else if (!frame_integrity_err_i && !frame_short_i &&
                                 frame_cmd_i == casc) begin
                        if (frame_arg_i != NVB_SELECT) begin
                            do_rpl = 1'b1; // anticollision answer
                            rk     = (s.state == ST_READY2) ? RPL_UID_CL2 : RPL_UID_CL1;
                        end else if (frame_len_i == LEN_SELECT && uid_match_i) begin
                            do_rpl = 1'b1;
                            if (s.state == ST_READY1) begin
                                next_s.state = ST_READY2;
                                rk = RPL_SAK_PART;
                            end else begin
                                next_s.state = ST_ACTIVE;
                                rk = RPL_SAK_DONE;
                            end
                        end else begin
                            fall = 1'b1;
                        end
                    end else begin
                        fall = 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (frame_integrity_err_i && !frame_short_i) begin
                        fall = 1'b1; do_rpl = 1'b1; rn = NIB_NACK_INTEGRITY;
                    end else if (!(is_read || is_write || is_halt) || !len_ok) begin
                        fall = 1'b1; // silent
                    end else if (!addr_ok && !is_write) begin
                        fall = 1'b1; do_rpl = 1'b1; rn = NIB_NACK_ADDRESS;
                    end else if (is_halt) begin
                        next_s.state     = ST_HALT; // no reply
                        next_s.from_halt = 1'b1;
                    end else begin
                        issue = 1'b1;
                    end
                end
            endcase
        end
        // memory result: failures are address or other errors
        if (s.mem_wait && mem_done_i) begin
            next_s.mem_wait = 1'b0;
            do_rpl = 1'b1;
            if (mem_fail_i) begin
                fall = 1'b1; rn = NIB_NACK_ADDRESS;
            end else if (s.mem_op == OP_READ_TWO_BLOCKS || s.mem_op == OP_READ_FOUR_BLOCKS) begin
                rk = RPL_MEM_DATA;
            end else begin
                rn = NIB_ACK;
            end
        end
        if (issue) begin
            next_s.mem_req  = 1'b1;
            next_s.mem_wait = 1'b1;
            next_s.mem_op   = frame_cmd_i;
            next_s.mem_addr = frame_arg_i;
        end
        if (fall) begin
            next_s.state = s.from_halt ? ST_HALT : ST_IDLE;
        end
        if (do_rpl) begin
            next_s.rpl_start = 1'b1;
            next_s.rpl_pend  = 1'b1;
            next_s.rpl_kind  = rk;
            next_s.rpl_nib   = rn;
        end
        next_s.limited = next_s.cfg[CFG_PROTECT_BIT] && !next_s.verified;
    end

    // field loss clears everything, including the origin record
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s           <= '0;
            s.state     <= ST_IDLE;
            s.boot_go   <= 1'b1;
            s.cfg       <= CFG_RESET;
            s.rpl_kind  <= RPL_NIBBLE;
        end else begin
            s <= next_s;
        end
    end

    assign state_o          = s.state;
    assign from_halt_o      = s.from_halt;
    assign ready_o          = s.ready;
    assign cfg_o            = s.cfg;
    assign access_limited_o = s.limited;
    assign mem_req_o        = s.mem_req;
    assign mem_op_o         = s.mem_op;
    assign mem_addr_o       = s.mem_addr;
    assign reply_valid_o    = s.rpl_valid;
    assign reply_kind_o     = s.rpl_kind;
    assign reply_nibble_o   = s.rpl_nib;

    // helper: cycles since the last reply launch
    logic [15:0] dly_cnt;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dly_cnt <= 16'h0000;
        end else if (s.rpl_start) begin
            dly_cnt <= 16'h0001;
        end else if (dly_cnt != 16'hFFFF) begin
            dly_cnt <= dly_cnt + 16'h0001;
        end
    end

    AST_IDLE_SILENT: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == ST_IDLE && fv && !(reqa || wupa) |=> s.state == ST_IDLE && !s.rpl_start)
        else $error("idle left or answered on a foreign frame");
    AST_HALT_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == ST_HALT && fv |=> (s.state == ST_READY1) == $past(wupa && !frame_integrity_err_i))
        else $error("halt left without wake-up or wake-up ignored");
    AST_HALT_CMD: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == ST_ACTIVE && fv && is_halt && !frame_integrity_err_i && len_ok && addr_ok
        |=> s.state == ST_HALT && !s.rpl_pend)
        else $error("halt command not obeyed silently");
    AST_SELECT1: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == ST_READY1 && fv && !frame_integrity_err_i && !frame_short_i &&
        frame_cmd_i == OP_CASCADE1 && frame_arg_i == NVB_SELECT &&
        frame_len_i == LEN_SELECT && uid_match_i
        |=> s.state == ST_READY2 && s.rpl_kind == RPL_SAK_PART)
        else $error("cascade-1 select did not reach ready2");
    AST_ORIGIN: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.state == ST_HALT |-> s.from_halt) and (s.state == ST_IDLE |-> !s.from_halt))
        else $error("origin record disagrees with rest state");
    AST_READ_JUMP: assert property (@(posedge clk_i) disable iff (rst_i)
        in_ready && fv && is_read && !frame_integrity_err_i && len_ok && addr_ok
        |=> s.state == ST_ACTIVE && s.mem_req ##1 !s.mem_req)
        else $error("read shortcut failed");
    AST_MEM_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
        s.mem_req |-> s.state == ST_ACTIVE)
        else $error("memory access outside active");
    AST_NACK_INTEGRITY: assert property (@(posedge clk_i) disable iff (rst_i)
        s.state == ST_ACTIVE && fv && frame_integrity_err_i && !frame_short_i
        |=> s.rpl_pend && s.rpl_nib == NIB_NACK_INTEGRITY && s.state != ST_ACTIVE)
        else $error("integrity error not answered with integrity nack");
    AST_CFG_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(s.cfg) |-> $past(fv && (reqa || wupa)))
        else $error("configuration changed without request or wake-up");
    AST_REPLY_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
        s.rpl_valid |-> dly_cnt == 16'(REPLY_DELAY_CYCLES + 2))
        else $error("reply delay wrong");
    AST_NOT_READY: assert property (@(posedge clk_i) disable iff (rst_i)
        !s.ready |=> s.state == ST_IDLE)
        else $error("frame taken before start-up delay");
endmodule : cts_tag_fsm
`default_nettype wire

// ===== tb.sv
// self-checking testbench of the tag protocol state machine
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cts_pkg::*;
    logic          clk_i = 1'b0, rst_i = 1'b1;
    logic          frame_valid_i = 1'b0, frame_short_i = 1'b0;
    logic [7:0]    frame_cmd_i = 8'h00, frame_arg_i = 8'h00, cfg_byte_i = 8'h01;
    logic [4:0]    frame_len_i = 5'h00;
    logic          frame_integrity_err_i = 1'b0, uid_match_i = 1'b0, pwd_ok_i = 1'b0;
    logic          mem_done_i, mem_fail_i, fail_mode = 1'b0;
    cts_state_type state_o;
    cts_reply_type reply_kind_o;
    logic          from_halt_o, ready_o, access_limited_o, mem_req_o, reply_valid_o;
    logic [7:0]    cfg_o, mem_op_o, mem_addr_o;
    logic [3:0]    reply_nibble_o;
    int            num_errors = 0, samples_checked = 0;

    always #25 clk_i = ~clk_i;

    cts_tag_fsm u_cts_tag_fsm (.clk_i(clk_i), .rst_i(rst_i), .frame_valid_i(frame_valid_i),
        .frame_short_i(frame_short_i), .frame_cmd_i(frame_cmd_i), .frame_arg_i(frame_arg_i),
        .frame_len_i(frame_len_i), .frame_integrity_err_i(frame_integrity_err_i),
        .uid_match_i(uid_match_i), .cfg_byte_i(cfg_byte_i), .pwd_ok_i(pwd_ok_i),
        .mem_done_i(mem_done_i), .mem_fail_i(mem_fail_i), .state_o(state_o),
        .from_halt_o(from_halt_o), .ready_o(ready_o), .cfg_o(cfg_o),
        .access_limited_o(access_limited_o), .mem_req_o(mem_req_o), .mem_op_o(mem_op_o),
        .mem_addr_o(mem_addr_o), .reply_valid_o(reply_valid_o), .reply_kind_o(reply_kind_o),
        .reply_nibble_o(reply_nibble_o));
    cts_mem_model u_cts_mem_model (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
        .fail_mode_i(fail_mode), .mem_done_o(mem_done_i), .mem_fail_o(mem_fail_i));

    task test_done;
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one frame, valid for exactly one sampling edge
    task send(input logic s, input logic [7:0] c, input logic [7:0] a,
              input logic [4:0] l, input logic e);
        @(posedge clk_i);
        frame_valid_i <= 1'b1;
        frame_short_i <= s;
        frame_cmd_i <= c;
        frame_arg_i <= a;
        frame_len_i <= l;
        frame_integrity_err_i <= e;
        @(posedge clk_i);
        frame_valid_i <= 1'b0;
    endtask : send

    // silent frames need the full window to prove that nothing comes back
    task wait_reply(input logic exp, input int dly, input cts_reply_type kind,
                    input logic [3:0] nib);
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 2100) begin
            @(posedge clk_i);
            #1;
            n++;
            if (reply_valid_o === 1'b1) seen = 1'b1;
        end
        check("reply_seen", seen, exp);
        if (seen && exp) begin
            // launch register plus result register add two cycles to the count
            if (dly > 0) check("reply_delay", 16'(n), 16'(REPLY_DELAY_CYCLES + 2));
            check("reply_kind", reply_kind_o, kind);
            if (kind == RPL_NIBBLE) check("reply_nibble", reply_nibble_o, nib);
        end
    endtask : wait_reply

    task chk_state(input cts_state_type s, input logic h);
        check("state", state_o, s);
        check("from_halt", from_halt_o, h);
    endtask : chk_state

    task do_reset;
        int n;
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        send(1'b1, OP_REQA, 8'h00, 5'h01, 1'b0); // early command is dropped
        n = 2;
        while (ready_o !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("ready_delay", 16'(n), 16'(STARTUP_CYCLES + 2));
        chk_state(ST_IDLE, 1'b0);
        check("cfg_cleared", cfg_o, 8'h00);
        if (n >= 3000) test_done();
    endtask : do_reset

    // wake-up from halt, then read shortcut into the starred active state
    task wake_active(input logic [7:0] addr);
        send(1'b1, OP_WUPA, 8'h00, 5'h01, 1'b0);
        wait_reply(1'b1, 2001, RPL_ATQA, 4'h0);
        chk_state(ST_READY1, 1'b1);
        send(1'b0, OP_READ_TWO_BLOCKS, addr, LEN_READ, 1'b0);
        wait_reply(1'b1, 0, RPL_MEM_DATA, 4'h0);
        chk_state(ST_ACTIVE, 1'b1);
    endtask : wake_active

    // idle, anticollision, selection, protected access and halt
    task t_select;
        send(1'b0, OP_READ_FOUR_BLOCKS, 8'h00, LEN_READ, 1'b0);
        wait_reply(1'b0, 0, RPL_ATQA, 4'h0);
        chk_state(ST_IDLE, 1'b0);
        send(1'b1, OP_REQA, 8'h00, 5'h01, 1'b0);
        wait_reply(1'b1, 2001, RPL_ATQA, 4'h0);
        chk_state(ST_READY1, 1'b0);
        check("cfg", cfg_o, 8'h01);
        check("limited", access_limited_o, 1'b1);
        cfg_byte_i <= 8'h00;
        uid_match_i <= 1'b1;
        send(1'b0, OP_CASCADE1, 8'h20, 5'h02, 1'b0);
        wait_reply(1'b1, 2001, RPL_UID_CL1, 4'h0);
        send(1'b0, OP_CASCADE1, NVB_SELECT, LEN_SELECT, 1'b0);
        wait_reply(1'b1, 2001, RPL_SAK_PART, 4'h0);
        chk_state(ST_READY2, 1'b0);
        send(1'b0, OP_CASCADE2, NVB_SELECT, LEN_SELECT, 1'b0);
        wait_reply(1'b1, 2001, RPL_SAK_DONE, 4'h0);
        chk_state(ST_ACTIVE, 1'b0);
        check("cfg_kept", cfg_o, 8'h01);
        pwd_ok_i <= 1'b1;
        @(posedge clk_i);
        pwd_ok_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("unlimited", access_limited_o, 1'b0);
        send(1'b0, OP_READ_FOUR_BLOCKS, 8'h0E, LEN_READ, 1'b0);
        #1;
        check("mem_req", mem_req_o, 1'b1);
        wait_reply(1'b1, 0, RPL_MEM_DATA, 4'h0);
        check("mem_op", mem_op_o, OP_READ_FOUR_BLOCKS);
        check("mem_addr", mem_addr_o, 8'h0E);
        send(1'b0, OP_HALT, 8'h0F, LEN_HALT, 1'b0);
        wait_reply(1'b0, 0, RPL_ATQA, 4'h0);
        chk_state(ST_HALT, 1'b1);
    endtask : t_select

    // halt behaviour and error paths of ready and active back to the starred origin
    task t_errors;
        send(1'b1, OP_REQA, 8'h00, 5'h01, 1'b0);
        wait_reply(1'b0, 0, RPL_ATQA, 4'h0);
        chk_state(ST_HALT, 1'b1);
        send(1'b1, OP_WUPA, 8'h00, 5'h01, 1'b0);
        wait_reply(1'b1, 2001, RPL_ATQA, 4'h0);
        check("cfg_relatched", cfg_o, 8'h00);
        send(1'b0, OP_WRITE_ONE_BLOCK, 8'h04, LEN_WRITE_ONE, 1'b0);
        wait_reply(1'b0, 0, RPL_ATQA, 4'h0);
        chk_state(ST_HALT, 1'b1);
        send(1'b1, OP_WUPA, 8'h00, 5'h01, 1'b0);
        wait_reply(1'b1, 2001, RPL_ATQA, 4'h0);
        send(1'b0, OP_READ_TWO_BLOCKS, 8'h10, LEN_READ, 1'b0);
        wait_reply(1'b1, 0, RPL_NIBBLE, NIB_NACK_ADDRESS);
        chk_state(ST_HALT, 1'b1);
        wake_active(8'h0F);
        send(1'b0, OP_READ_TWO_BLOCKS, 8'h01, 5'h05, 1'b0);
        wait_reply(1'b0, 0, RPL_ATQA, 4'h0);
        chk_state(ST_HALT, 1'b1);
        wake_active(8'h00);
        send(1'b0, OP_WRITE_ONE_BLOCK, 8'h04, LEN_WRITE_ONE, 1'b0);
        wait_reply(1'b1, 0, RPL_NIBBLE, NIB_ACK);
        fail_mode <= 1'b1;
        send(1'b0, OP_READ_TWO_BLOCKS, 8'h01, LEN_READ, 1'b0);
        wait_reply(1'b1, 0, RPL_NIBBLE, NIB_NACK_ADDRESS);
        chk_state(ST_HALT, 1'b1);
        fail_mode <= 1'b0;
        cfg_byte_i <= 8'h01;
        wake_active(8'h02);
        send(1'b0, OP_READ_TWO_BLOCKS, 8'h01, LEN_READ, 1'b1);
        wait_reply(1'b1, 2001, RPL_NIBBLE, NIB_NACK_INTEGRITY);
        chk_state(ST_HALT, 1'b1);
    endtask : t_errors

    // main sequence; a second reset after the last test stands for loss of field
    initial begin
        do_reset();
        t_select();
        t_errors();
        do_reset();
        test_done();
    end
endmodule : tb
`default_nettype wire
